// >>> design/host_port_access_front_end.sv
// Host port front end: strobe, cycle decode, ready and memory DMA
//
// Behaviour
// - Access select 00 control, 01 data incrementing, 10 address, 11 data plain.
// - Select levels are latched on the rising edge of the internal strobe, when it becomes active.
// - Internal strobe comes from port select and data strobes; ignored when deselected.
// - Ready is forced low whenever port select is high.
// - After latching, the access named by the cycle type starts.
// - Data read fetches memory at read address into the data window.
// - During reads, ready low means bus data valid, high means not yet.
// - Held write data is stored to memory at the write address.
// - Ready shows not ready while internal resources are busy.
// - Incrementing data access advances the address register by one afterwards.
// - Plain data access leaves both address registers unchanged.
// - Memory transfers are done by the port's own DMA logic alone.
// - Unsplit mode: address write loads both read and write registers.
// - Control accesses ignore halfword identifier, same 16-bit register.
// - Split mode increments only the register used for that direction.
`timescale 1ns/1ps
`include "host_port_defs.svh"
module host_port_access_front_end (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [1:0] i_access_select,
  input wire logic i_read_write_select,
  input wire logic i_halfword_identifier,
  input wire logic i_port_select_n,
  input wire logic i_data_strobe_a,
  input wire logic i_data_strobe_b,
  input wire logic [15:0] i_host_data_bus,
  output logic [15:0] o_host_data_bus,
  output logic o_host_data_bus_oe,
  output logic o_host_ready,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output logic [15:0] o_port_control_reg,
  output logic [31:0] o_read_address_reg,
  output logic [31:0] o_write_address_reg,
  output host_port_pkg::cycle_kind_t o_cycle_kind
);
  import host_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [22:0] pins;
  logic [1:0] acc_s;
  logic rw_s;
  logic hw_s;
  logic cs_n_s;
  logic ds_a_s;
  logic ds_b_s;
  logic [15:0] data_s;
  logic strobe;
  logic strobe_q;
  logic strobe_fall;
  logic strobe_rise;
  logic cyc_read;
  logic cyc_second;
  cycle_kind_t kind;
  port_state_t state;
  logic [31:0] data_window_reg;
  logic busy;

  sync2 #(.WIDTH(23)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async({i_access_select, i_read_write_select, i_halfword_identifier,
              i_port_select_n, i_data_strobe_a, i_data_strobe_b, i_host_data_bus}),
    .o_sync(pins)
  );
  assign {acc_s, rw_s, hw_s, cs_n_s, ds_a_s, ds_b_s, data_s} = pins;

  function automatic logic is_data(input cycle_kind_t k);
    is_data = (k == CYC_DATA_INC) || (k == CYC_DATA_NOINC);
  endfunction : is_data

  // Strobes that differ mean active, so a single strobe of either polarity works
  assign strobe = !cs_n_s && (ds_a_s ^ ds_b_s);
  assign strobe_fall = strobe && !strobe_q;
  assign strobe_rise = !strobe && strobe_q;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      strobe_q <= 1'b0;
    else if (i_ce)
      strobe_q <= strobe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control latch on strobe activation
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      kind <= CYC_CONTROL;
      cyc_read <= 1'b0;
      cyc_second <= 1'b0;
    end
    else if (i_ce && strobe_fall)
    begin
      kind <= cycle_kind_t'(acc_s);
      cyc_read <= rw_s;
      cyc_second <= hw_s;
    end
  end
  assign o_cycle_kind = kind;

  ////////////////////////////////////////////////////////////////////////////
  // Control register; halfword identifier is not consulted
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_port_control_reg <= `CONTROL_RESET;
    else if (i_ce && strobe_rise && kind == CYC_CONTROL && !cyc_read)
      o_port_control_reg <= data_s & `CONTROL_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address registers: host loads and DMA post-increments
  logic split;
  logic addr_sel_read;
  logic first_is_high;
  logic [31:0] next_addr;
  assign split = o_port_control_reg[`BIT_SPLIT_ADDRESS];
  assign addr_sel_read = o_port_control_reg[`BIT_ADDR_REG_SELECT];
  assign first_is_high = !o_port_control_reg[`BIT_HALFWORD_ORDER];

  function automatic logic [31:0] put_half(input logic [31:0] w, input logic [15:0] d,
                                           input logic hi);
    put_half = hi ? {d, w[15:0]} : {w[31:16], d};
  endfunction : put_half

  logic addr_wr;
  logic inc_done;
  assign addr_wr = i_ce && strobe_rise && kind == CYC_ADDRESS && !cyc_read;
  assign inc_done = i_ce && i_mem_ack && kind == CYC_DATA_INC;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_read_address_reg <= `ADDR_RESET;
    else if (addr_wr && (!split || addr_sel_read))
      o_read_address_reg <= put_half(o_read_address_reg, data_s, cyc_second ^ first_is_high);
    else if (inc_done && (!split || state == ST_MEM_READ))
      o_read_address_reg <= o_read_address_reg + `ADDR_STEP;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_write_address_reg <= `ADDR_RESET;
    else if (addr_wr && (!split || !addr_sel_read))
      o_write_address_reg <= put_half(o_write_address_reg, data_s, cyc_second ^ first_is_high);
    else if (inc_done && (!split || state == ST_MEM_WRITE))
      o_write_address_reg <= o_write_address_reg + `ADDR_STEP;
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA sequencer, no processor involvement
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      state <= ST_IDLE;
    else if (i_ce)
    begin
      unique case (state)
        ST_IDLE:
          if (strobe_fall && acc_s[0] && rw_s && !hw_s)
            state <= ST_MEM_READ;
          else if (strobe_rise && is_data(kind) && !cyc_read && cyc_second)
            state <= ST_MEM_WRITE;
        ST_MEM_READ:
          if (i_mem_ack)
            state <= ST_READ_WAIT;
        ST_READ_WAIT:
          state <= ST_WAIT_END;
        ST_WAIT_END:
          if (strobe_rise || !strobe)
            state <= ST_IDLE;
        ST_MEM_WRITE:
          if (i_mem_ack)
            state <= ST_IDLE;
      endcase
    end
  end

  assign o_mem_req = (state == ST_MEM_READ) || (state == ST_MEM_WRITE);
  assign o_mem_we = (state == ST_MEM_WRITE);
  assign o_mem_addr = o_mem_we ? o_write_address_reg : o_read_address_reg;
  assign o_mem_wdata = data_window_reg;

  // Data window: filled by memory on reads, by the bus on write strobe rise
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      data_window_reg <= `ADDR_RESET;
    else if (i_ce && state == ST_MEM_READ && i_mem_ack)
      data_window_reg <= i_mem_rdata;
    else if (i_ce && strobe_rise && is_data(kind) && !cyc_read && state == ST_IDLE)
      data_window_reg <= put_half(data_window_reg, data_s, cyc_second ^ first_is_high);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host bus drive and ready
  logic rd_hi;
  assign rd_hi = cyc_second ^ first_is_high;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_host_data_bus <= 16'h0000;
    else if (i_ce)
      unique case (kind)
        CYC_CONTROL:
          o_host_data_bus <= {7'h00, o_port_control_reg[`BIT_HALFWORD_ORDER],
                              o_port_control_reg[7:0]};
        CYC_ADDRESS:
          o_host_data_bus <= (split && !addr_sel_read) ?
            (rd_hi ? o_write_address_reg[31:16] : o_write_address_reg[15:0]) :
            (rd_hi ? o_read_address_reg[31:16] : o_read_address_reg[15:0]);
        default:
          o_host_data_bus <= rd_hi ? data_window_reg[31:16] : data_window_reg[15:0];
      endcase
  end
  assign o_host_data_bus_oe = strobe && cyc_read && !strobe_fall;

  // Ready high here means wait; fetch or store in flight holds it
  assign busy = (state == ST_MEM_READ) || (state == ST_READ_WAIT) || (state == ST_MEM_WRITE);
  assign o_host_ready = !cs_n_s && busy;

  ////////////////////////////////////////////////////////////////////////////
  deselect_no_ready_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    cs_n_s |-> !o_host_ready) else $error("ready high while deselected");
  strobe_ignored_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    cs_n_s |-> !strobe) else $error("strobe active while deselected");
  latch_kind_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && strobe_fall) |=> kind == cycle_kind_t'($past(acc_s))) else $error("kind not latched");
  latch_dir_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && strobe_fall) |=> cyc_read == $past(rw_s)) else $error("direction not latched");
  sequence s_fetch;
    state == ST_MEM_READ && i_mem_ack && i_ce;
  endsequence
  read_fetch_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_fetch |=> data_window_reg == $past(i_mem_rdata)) else $error("fetch lost");
  sequence s_store;
    i_ce && state == ST_IDLE && strobe_rise && !cyc_read && cyc_second &&
      (kind == CYC_DATA_INC || kind == CYC_DATA_NOINC);
  endsequence
  write_addr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_store |=> o_mem_we && o_mem_addr == $past(o_write_address_reg))
    else $error("store not at write address");
  inc_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (inc_done && o_mem_we && !addr_wr) |=> o_write_address_reg == $past(o_write_address_reg) + 1)
    else $error("no increment");
  noinc_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && i_mem_ack && kind == CYC_DATA_NOINC && !addr_wr)
      |=> $stable(o_read_address_reg) && $stable(o_write_address_reg))
    else $error("address moved");
  busy_ready_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (busy && !cs_n_s) |-> o_host_ready) else $error("busy but ready low");
endmodule : host_port_access_front_end

// >>> design/host_port_defs.svh
// Constants for the host port front end
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH
`define SEL_CONTROL 2'h0
`define SEL_DATA_INC 2'h1
`define SEL_ADDRESS 2'h2
`define SEL_DATA_NOINC 2'h3
`define BIT_HALFWORD_ORDER 0
`define BIT_SPLIT_ADDRESS 1
`define BIT_ADDR_REG_SELECT 2
`define BIT_ORDER_STATUS 8
`define CONTROL_MASK 16'h0007
`define CONTROL_RESET 16'h0000
`define ADDR_RESET 32'h0000_0000
`define ADDR_STEP 32'h0000_0001
`endif

// >>> design/host_port_pkg.sv
// Types for the host port front end
package host_port_pkg;
  typedef enum logic [1:0] {
    CYC_CONTROL,
    CYC_DATA_INC,
    CYC_ADDRESS,
    CYC_DATA_NOINC
  } cycle_kind_t;
  typedef enum {
    ST_IDLE,
    ST_MEM_READ,
    ST_READ_WAIT,
    ST_WAIT_END,
    ST_MEM_WRITE
  } port_state_t;
endpackage : host_port_pkg

// >>> design/sync2.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else if (i_ce)
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : sync2

// >>> tb/host_port_access_front_end_test.sv
// Self-checking bench for the host port front end
`timescale 1ns/1ps
`include "host_port_defs.svh"
module host_port_access_front_end_test;
  import host_port_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [1:0] sel_q = 2'h0;
  logic rw_q = 1'b1;
  logic hw_q = 1'b0;
  logic cs_n = 1'b1;
  logic ds_a = 1'b1;
  logic ds_b = 1'b1;
  logic [15:0] wd_q = 16'h0000;
  logic [3:0] dly_q = 4'h0;
  logic [15:0] rd_bus, ctrl, hd_wire;
  logic oe, rdy, req, we, ack, saw_busy, split;
  logic [31:0] maddr, mwdata, mrdata, raddr, waddr, last_addr, last_wdata, raddr_e, waddr_e;
  logic [7:0] writes;
  logic order = 1'b0;
  cycle_kind_t kind;
  int n_errors = 0;
  int total_checks = 0;
  assign hd_wire = oe ? rd_bus : wd_q;
  host_port_access_front_end uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_access_select(sel_q),
    .i_read_write_select(rw_q), .i_halfword_identifier(hw_q), .i_port_select_n(cs_n),
    .i_data_strobe_a(ds_a), .i_data_strobe_b(ds_b), .i_host_data_bus(hd_wire),
    .o_host_data_bus(rd_bus), .o_host_data_bus_oe(oe), .o_host_ready(rdy), .o_mem_req(req),
    .o_mem_we(we), .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ack(ack),
    .i_mem_rdata(mrdata), .o_port_control_reg(ctrl), .o_read_address_reg(raddr),
    .o_write_address_reg(waddr), .o_cycle_kind(kind));
  mem_model mem (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_delay(dly_q), .i_req(req), .i_we(we),
    .i_addr(maddr), .i_wdata(mwdata), .o_ack(ack), .o_rdata(mrdata),
    .o_last_addr(last_addr), .o_last_wdata(last_wdata), .o_writes(writes));
  initial
  begin
    forever #2 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Whole host halfword transfer; waits on ready before releasing the strobe
  task automatic hcyc(input logic [1:0] s, input logic r, input logic h,
                      input logic [15:0] d, output logic [15:0] rd);
    int n;
    n = 0;
    sel_q = s;
    rw_q = r;
    hw_q = h;
    wd_q = d;
    cs_n = 1'b0;
    tick(3);
    ds_a = 1'b0;
    tick(6);
    chk({30'h0, kind}, {30'h0, s});
    while (rdy !== 1'b0 && n < 80)
    begin
      saw_busy = 1'b1;
      tick(1);
      n++;
    end
    chk({31'h0, rdy}, 32'h0);
    rd = rd_bus;
    if (r)
      chk({31'h0, oe}, 32'h1);
    ds_a = 1'b1;
    ds_b = 1'b1;
    tick(5);
  endtask : hcyc
  task automatic set_addr(input logic [31:0] a);
    logic [15:0] rd;
    hcyc(`SEL_ADDRESS, 1'b0, 1'b0, order ? a[15:0] : a[31:16], rd);
    hcyc(`SEL_ADDRESS, 1'b0, 1'b1, order ? a[31:16] : a[15:0], rd);
  endtask : set_addr
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_control();
    logic [15:0] rd;
    hcyc(`SEL_CONTROL, 1'b0, 1'b1, 16'hFFFF, rd);
    chk({16'h0, ctrl}, 32'h0000_0007);
    hcyc(`SEL_CONTROL, 1'b1, 1'b0, 16'h0000, rd);
    chk({16'h0, rd}, 32'h0000_0107);
    hcyc(`SEL_CONTROL, 1'b0, 1'b0, 16'h0000, rd);
    chk({16'h0, ctrl}, 32'h0);
  endtask : test_control
  task automatic test_read(input logic [1:0] s, input logic [3:0] d);
    logic [15:0] rd;
    logic [31:0] w;
    logic [31:0] a;
    a = raddr_e;
    w = a ^ 32'h5A5A_C3C3;
    dly_q = d;
    saw_busy = 1'b0;
    hcyc(s, 1'b1, 1'b0, 16'h0000, rd);
    chk({16'h0, rd}, {16'h0, order ? w[15:0] : w[31:16]});
    chk(last_addr, a);
    if (d != 4'h0)
      chk({31'h0, saw_busy}, 32'h1);
    hcyc(s, 1'b1, 1'b1, 16'h0000, rd);
    chk({16'h0, rd}, {16'h0, order ? w[31:16] : w[15:0]});
    if (s == `SEL_DATA_INC)
    begin
      raddr_e++;
      if (!split)
        waddr_e++;
    end
    chk(raddr, raddr_e);
    chk(waddr, waddr_e);
  endtask : test_read
  task automatic test_write(input logic [1:0] s, input logic [31:0] d);
    logic [15:0] rd;
    logic [7:0] n0;
    n0 = writes;
    hcyc(s, 1'b0, 1'b0, order ? d[15:0] : d[31:16], rd);
    hcyc(s, 1'b0, 1'b1, order ? d[31:16] : d[15:0], rd);
    tick(20);
    chk({24'h0, writes}, {24'h0, n0 + 8'h01});
    chk(last_addr, waddr_e);
    chk(last_wdata, d);
    if (s == `SEL_DATA_INC)
    begin
      waddr_e++;
      if (!split)
        raddr_e++;
    end
    chk(waddr, waddr_e);
    chk(raddr, raddr_e);
  endtask : test_write
  // Host drops select in mid-fetch, then strobes while deselected
  task automatic test_deselect();
    dly_q = 4'hC;
    sel_q = `SEL_DATA_NOINC;
    rw_q = 1'b1;
    hw_q = 1'b0;
    cs_n = 1'b0;
    tick(3);
    ds_b = 1'b0;
    tick(6);
    chk({31'h0, rdy}, 32'h1);
    cs_n = 1'b1;
    tick(3);
    chk({31'h0, rdy}, 32'h0);
    ds_a = 1'b1;
    ds_b = 1'b1;
    tick(25);
    sel_q = `SEL_CONTROL;
    rw_q = 1'b0;
    wd_q = 16'h0005;
    ds_a = 1'b0;
    tick(6);
    ds_a = 1'b1;
    ds_b = 1'b1;
    tick(6);
    chk({16'h0, ctrl}, 32'h0);
    chk(raddr, raddr_e);
  endtask : test_deselect
  // Select and one data strobe driven as one shared host strobe
  task automatic shared_ctrl(input logic [15:0] d);
    sel_q = `SEL_CONTROL;
    rw_q = 1'b0;
    wd_q = d;
    cs_n = 1'b1;
    tick(3);
    cs_n = 1'b0;
    ds_a = 1'b0;
    tick(6);
    cs_n = 1'b1;
    ds_a = 1'b1;
    tick(6);
    chk({16'h0, ctrl}, {16'h0, d & `CONTROL_MASK});
  endtask : shared_ctrl
  task automatic test_split();
    shared_ctrl(16'h0003);
    split = 1'b1;
    order = 1'b1;
    set_addr(32'h0000_0200);
    waddr_e = 32'h0000_0200;
    chk(waddr, waddr_e);
    chk(raddr, raddr_e);
    test_write(`SEL_DATA_INC, 32'hCAFE_0042);
    test_read(`SEL_DATA_INC, 4'h0);
  endtask : test_split
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    split = 1'b0;
    tick(20);
    i_rst_n = 1'b1;
    tick(4);
    test_control();
    set_addr(32'h0001_0010);
    raddr_e = 32'h0001_0010;
    waddr_e = raddr_e;
    chk(raddr, raddr_e);
    chk(waddr, waddr_e);
    test_read(`SEL_DATA_INC, 4'h9);
    test_read(`SEL_DATA_NOINC, 4'h0);
    test_write(`SEL_DATA_NOINC, 32'h1234_ABCD);
    test_write(`SEL_DATA_INC, 32'h8765_0F0F);
    test_deselect();
    test_split();
    close_out();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule : host_port_access_front_end_test

// >>> tb/mem_model.sv
// Memory responder behind the port's DMA side
`timescale 1ns/1ps
module mem_model (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_delay,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic [31:0] o_last_addr,
  output logic [31:0] o_last_wdata,
  output logic [7:0] o_writes
);
  logic [3:0] wait_cnt;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_ack <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata <= 32'h0;
      o_writes <= 8'h00;
    end
    else if (o_ack)
    begin
      o_ack <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata <= ~o_rdata;
    end
    else if (i_req && wait_cnt == i_delay)
    begin
      // One-cycle answer; store only through the port's own requests
      o_ack <= 1'b1;
      o_rdata <= i_addr ^ 32'h5A5A_C3C3;
      o_last_addr <= i_addr;
      o_last_wdata <= i_wdata;
      o_writes <= o_writes + {7'h00, i_we};
    end
    else
    begin
      // Idle read data keeps moving so stale values never look valid
      wait_cnt <= wait_cnt + {3'h0, i_req};
      o_rdata <= ~o_rdata;
    end
  end
endmodule : mem_model
